/* File: radio_repeater_forwarding.sv */
// Repeater forwarding, parameter store and reload sequencing of a serial radio module.
// Assumes mode pins from outside (synchronised here), all other inputs on mclk.
module radio_repeater_forwarding (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [1:0] mode_select_pins,
	input wire logic factory_default_req,
	input wire logic cfg_wr_valid,
	input wire repeater_pkg::cfg_write_t cfg_wr,
	output logic cfg_wr_ack,
	output logic cfg_wr_err,
	input wire logic air_rx_valid,
	output logic air_rx_ready,
	input wire repeater_pkg::air_packet_t air_rx_pkt,
	output logic air_tx_valid,
	input wire logic air_tx_ready,
	output repeater_pkg::air_packet_t air_tx_pkt,
	input wire logic user_tx_valid,
	output logic user_tx_ready,
	input wire logic [7:0] user_tx_data,
	output logic user_rx_valid,
	output logic [7:0] user_rx_data,
	output logic status_aux,
	output logic low_power,
	output logic repeating
);
	import repeater_pkg::*;

	// ==========================================================
	// Mode pin synchroniser
	logic [1:0] mode_meta_reg;
	logic [1:0] mode_sync_reg;
	op_mode_t mode_prev_reg;
	op_mode_t mode_now;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_meta_reg <= 2'h0;
			mode_sync_reg <= 2'h0;
			mode_prev_reg <= MODE_NORMAL;
		end else begin
			mode_meta_reg <= mode_select_pins;
			mode_sync_reg <= mode_meta_reg;
			mode_prev_reg <= mode_now;
		end
	end
	assign mode_now = op_mode_t'(mode_sync_reg);

	// ==========================================================
	// Reload sequencer
	run_state_t state_reg;
	run_state_t state_next;
	logic [3:0] load_idx_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RELOAD: begin
				if (load_idx_reg == PARAM_LAST) state_next = ST_RUN;
			end
			ST_RUN: begin
				if (mode_prev_reg == MODE_SLEEP && mode_now != MODE_SLEEP) state_next = ST_RELOAD;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_RELOAD;
			load_idx_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			load_idx_reg <= (state_reg == ST_RELOAD && state_next == ST_RELOAD) ? load_idx_reg + 4'h1 : 4'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			status_aux <= 1'b0;
		end else begin
			status_aux <= (state_next == ST_RUN);
		end
	end

	// ==========================================================
	// Parameter store and working copy
	logic [7:0] store_reg [PARAM_COUNT];
	logic [7:0] work_reg [PARAM_COUNT];
	logic cfg_ok;
	logic cfg_range_ok;

	assign cfg_range_ok = (cfg_wr.index <= PARAM_LAST) &&
		!(cfg_wr.index == IDX_CHANNEL && cfg_wr.value > CHANNEL_MAX);
	assign cfg_ok = cfg_wr_valid && mode_now == MODE_CONFIG && state_reg == ST_RUN && cfg_range_ok;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < PARAM_COUNT; i++) store_reg[i] <= DEFAULT_IMAGE[i*8 +: 8];
		end else if (factory_default_req) begin
			for (int i = 0; i < PARAM_COUNT; i++) store_reg[i] <= DEFAULT_IMAGE[i*8 +: 8];
		end else if (cfg_ok) begin
			store_reg[cfg_wr.index] <= cfg_wr.value;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < PARAM_COUNT; i++) work_reg[i] <= 8'h00;
		end else if (state_reg == ST_RELOAD) begin
			work_reg[load_idx_reg] <= store_reg[load_idx_reg];
		end else if (cfg_ok && !factory_default_req) begin
			work_reg[cfg_wr.index] <= cfg_wr.value;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_wr_ack <= 1'b0;
			cfg_wr_err <= 1'b0;
		end else begin
			cfg_wr_ack <= cfg_ok && !factory_default_req;
			cfg_wr_err <= cfg_wr_valid && !cfg_ok;
		end
	end

	// ==========================================================
	// Mode decode
	logic repeat_cfg;
	logic repeating_now;
	logic [7:0] pair_hi;
	logic [7:0] pair_lo;
	logic [7:0] own_network_identifier;
	logic [15:0] own_addr;

	assign repeat_cfg = work_reg[IDX_REG3][REPEAT_BIT];
	assign repeating_now = repeat_cfg && mode_now == MODE_NORMAL && state_reg == ST_RUN;
	assign pair_hi = work_reg[IDX_ADDR_HIGH];
	assign pair_lo = work_reg[IDX_ADDR_LOW];
	assign own_network_identifier = work_reg[IDX_NETWORK_IDENTIFIER];
	assign own_addr = {work_reg[IDX_ADDR_HIGH], work_reg[IDX_ADDR_LOW]};

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			repeating <= 1'b0;
			low_power <= 1'b0;
		end else begin
			repeating <= repeating_now;
			low_power <= (mode_now == MODE_WOR || mode_now == MODE_SLEEP) && !repeat_cfg;
		end
	end

	// ==========================================================
	// Receive and user holding stages
	air_packet_t rx_hold_reg;
	air_packet_t usr_hold_reg;
	air_packet_t fwd_pkt;
	air_packet_t last_fwd_reg;
	logic rx_hold_v_reg;
	logic usr_hold_v_reg;
	logic last_fwd_v_reg;
	logic in_pair;
	logic echo;
	logic fwd_match;
	logic deliver;
	logic rx_consume;
	logic usr_consume;
	logic rx_hold_v_next;
	logic usr_hold_v_next;
	logic fifo_in_valid;
	logic fifo_in_ready;
	air_packet_t fifo_in_data;
	logic fwd_push;

	assign in_pair = rx_hold_reg.network_identifier == pair_hi ||
		rx_hold_reg.network_identifier == pair_lo;
	assign echo = last_fwd_v_reg && rx_hold_reg == last_fwd_reg;
	assign fwd_match = repeating_now && in_pair && !echo;
	always_comb begin
		fwd_pkt = rx_hold_reg;
		fwd_pkt.network_identifier = (rx_hold_reg.network_identifier == pair_hi) ? pair_lo : pair_hi;
	end
	assign deliver = !repeating_now && state_reg == ST_RUN && mode_now == MODE_NORMAL &&
		rx_hold_reg.network_identifier == own_network_identifier && rx_hold_reg.dest_addr == own_addr;
	assign rx_consume = rx_hold_v_reg && (!fwd_match || fifo_in_ready);
	assign fwd_push = rx_hold_v_reg && fwd_match && fifo_in_ready;
	assign fifo_in_valid = (rx_hold_v_reg && fwd_match) || (usr_hold_v_reg && !repeating_now);
	assign fifo_in_data = (rx_hold_v_reg && fwd_match) ? fwd_pkt : usr_hold_reg;
	assign usr_consume = usr_hold_v_reg && (repeating_now || (!(rx_hold_v_reg && fwd_match) && fifo_in_ready));
	assign rx_hold_v_next = (rx_hold_v_reg && !rx_consume) || (air_rx_valid && air_rx_ready);
	assign usr_hold_v_next = (usr_hold_v_reg && !usr_consume) || (user_tx_valid && user_tx_ready);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_hold_v_reg <= 1'b0;
			rx_hold_reg <= '0;
			air_rx_ready <= 1'b0;
		end else begin
			rx_hold_v_reg <= rx_hold_v_next;
			if (air_rx_valid && air_rx_ready) rx_hold_reg <= air_rx_pkt;
			air_rx_ready <= !rx_hold_v_next && state_next == ST_RUN;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			usr_hold_v_reg <= 1'b0;
			usr_hold_reg <= '0;
			user_tx_ready <= 1'b0;
		end else begin
			usr_hold_v_reg <= usr_hold_v_next;
			if (user_tx_valid && user_tx_ready) usr_hold_reg <= '{own_network_identifier, own_addr, user_tx_data};
			user_tx_ready <= !usr_hold_v_next && mode_now == MODE_NORMAL && !repeat_cfg &&
				state_next == ST_RUN;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			last_fwd_v_reg <= 1'b0;
			last_fwd_reg <= '0;
		end else if (fwd_push) begin
			last_fwd_v_reg <= 1'b1;
			last_fwd_reg <= fwd_pkt;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			user_rx_valid <= 1'b0;
			user_rx_data <= 8'h00;
		end else begin
			user_rx_valid <= rx_hold_v_reg && deliver;
			if (rx_hold_v_reg && deliver) user_rx_data <= rx_hold_reg.payload;
		end
	end

	// ==========================================================
	// Transmit FIFO and output register
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [PKT_W-1:0] fifo_out_data;

	pkt_fifo #(
		.WIDTH(PKT_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_out_ready = !air_tx_valid || air_tx_ready;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			air_tx_valid <= 1'b0;
			air_tx_pkt <= '0;
		end else if (fifo_out_ready) begin
			air_tx_valid <= fifo_out_valid;
			if (fifo_out_valid) air_tx_pkt <= air_packet_t'(fifo_out_data);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_RELOAD_AUX_LOW: assert property (state_reg == ST_RELOAD |-> !status_aux)
		else $error("status pin high during reload");
	AST_RELOAD_LEN: assert property ((state_reg == ST_RUN && state_next == ST_RELOAD) |=>
		(state_reg == ST_RELOAD)[*8] ##1 (state_reg == ST_RELOAD) ##1 (state_reg == ST_RUN && status_aux))
		else $error("reload length wrong");
	AST_SLEEP_EXIT: assert property ((state_reg == ST_RUN && mode_prev_reg == MODE_SLEEP &&
		mode_now != MODE_SLEEP) |=> state_reg == ST_RELOAD)
		else $error("no reload after sleep");
	AST_REPEAT_START: assert property (repeating |-> $past(mode_now == MODE_NORMAL && repeat_cfg))
		else $error("repeating outside normal mode");
	AST_FWD_SWAP: assert property (fwd_push |-> fifo_in_data.network_identifier ==
		((rx_hold_reg.network_identifier == pair_hi) ? pair_lo : pair_hi))
		else $error("forward network not swapped");
	AST_FOREIGN_DROP: assert property ((rx_hold_v_reg && repeating_now && !in_pair) |->
		rx_consume && !fwd_push ##1 !user_rx_valid)
		else $error("foreign packet not dropped");
	AST_USER_BLOCKED: assert property (repeating |-> !user_tx_ready && !user_rx_valid && !low_power)
		else $error("user path open while repeating");
	AST_DELIVER_MATCH: assert property (user_rx_valid |->
		$past(rx_hold_reg.dest_addr == own_addr && rx_hold_reg.network_identifier == own_network_identifier))
		else $error("delivery without address match");
	AST_CHANNEL_RANGE: assert property ((cfg_wr_valid && cfg_wr.index == IDX_CHANNEL &&
		cfg_wr.value > CHANNEL_MAX) |=> cfg_wr_err && !cfg_wr_ack)
		else $error("channel above range accepted");
	AST_CFG_MODE: assert property (cfg_wr_ack |-> $past(mode_now == MODE_CONFIG))
		else $error("write outside configuration mode");
	AST_FACTORY: assert property (factory_default_req |=> store_reg[IDX_REG0] == DEF_SEQUENCE[39:32] &&
		store_reg[IDX_CHANNEL] == DEF_CHANNEL && store_reg[IDX_ADDR_HIGH] == DEF_ADDR)
		else $error("factory image not loaded");
	AST_ONCE: assert property (fwd_push |=> last_fwd_v_reg && last_fwd_reg == $past(fwd_pkt))
		else $error("forwarded packet not remembered");

	COV_FORWARD: cover property (fwd_push ##[1:20] air_tx_valid);
	COV_DELIVER: cover property (user_rx_valid);
	COV_SLEEP_RELOAD: cover property (state_reg == ST_RUN ##1 state_reg == ST_RELOAD);
	COV_CFG_ERR: cover property (cfg_wr_err);

endmodule : radio_repeater_forwarding

/* File: repeater_pkg.sv */
// Constants, types and defaults shared by the repeater forwarding logic.
// Assumes one 10 MHz clock (mclk) and an active-low asynchronous reset.
package repeater_pkg;

	// ==========================================================
	// Clock
	localparam int MCLK_HZ = 10000000;

	// ==========================================================
	// Parameter store layout, one byte per index
	localparam int PARAM_COUNT = 9;
	localparam logic [3:0] PARAM_LAST = 4'h8;
	localparam logic [3:0] IDX_ADDR_HIGH = 4'h0;
	localparam logic [3:0] IDX_ADDR_LOW = 4'h1;
	localparam logic [3:0] IDX_NETWORK_IDENTIFIER = 4'h2;
	localparam logic [3:0] IDX_REG0 = 4'h3;
	localparam logic [3:0] IDX_REG1 = 4'h4;
	localparam logic [3:0] IDX_CHANNEL = 4'h5;
	localparam logic [3:0] IDX_REG3 = 4'h6;
	localparam logic [3:0] IDX_KEY_HIGH = 4'h7;
	localparam logic [3:0] IDX_KEY_LOW = 4'h8;
	localparam int REPEAT_BIT = 5;
	localparam logic [7:0] CHANNEL_MAX = 8'h50;

	// ==========================================================
	// Factory image, byte i at bits [8*i +: 8]
	localparam logic [7:0] DEF_ADDR = 8'h00;
	localparam logic [7:0] DEF_NETWORK_IDENTIFIER = 8'h00;
	localparam logic [7:0] DEF_CHANNEL = 8'h32;
	localparam logic [39:0] DEF_SEQUENCE = 40'h62_00_00_00_00;
	localparam logic [PARAM_COUNT*8-1:0] DEFAULT_IMAGE = {
		DEF_SEQUENCE[7:0], DEF_SEQUENCE[15:8], DEF_SEQUENCE[23:16], DEF_CHANNEL,
		DEF_SEQUENCE[31:24], DEF_SEQUENCE[39:32], DEF_NETWORK_IDENTIFIER, DEF_ADDR, DEF_ADDR};

	// ==========================================================
	// Modes on the mode-select pins, {pin1, pin0}
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_WOR = 2'h1,
		MODE_CONFIG = 2'h2,
		MODE_SLEEP = 2'h3
	} op_mode_t;

	typedef enum logic [1:0] {
		ST_RELOAD = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] network_identifier;
		logic [15:0] dest_addr;
		logic [7:0] payload;
	} air_packet_t;

	typedef struct packed {
		logic [3:0] index;
		logic [7:0] value;
	} cfg_write_t;

	localparam int PKT_W = $bits(air_packet_t);
	localparam int FIFO_DEPTH = 8;

endpackage : repeater_pkg

/* File: pkt_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; reset empties it.
module pkt_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	// ==========================================================
	// Storage and pointers
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != DEPTH_CNT);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					mem_reg[gi] <= '0;
				end else if (push && wr_ptr_reg == PW'(gi)) begin
					mem_reg[gi] <= in_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop && !push) begin
			count_reg <= count_reg - 1'b1;
		end
	end

endmodule : pkt_fifo

/* File: radio_air_model.sv */
// Air-side partner model: remote radio nodes feeding and hearing the repeater.
// Assumes mclk from the bench; outputs change on the falling edge.
module radio_air_model (
	input wire logic mclk,
	input wire logic stall,
	output logic air_rx_valid,
	input wire logic air_rx_ready,
	output repeater_pkg::air_packet_t air_rx_pkt,
	input wire logic air_tx_valid,
	output logic air_tx_ready,
	input wire repeater_pkg::air_packet_t air_tx_pkt
);
	timeunit 1ns;
	timeprecision 1ns;
	import repeater_pkg::*;

	air_packet_t send_q[$];
	air_packet_t heard_q[$];
	logic took;

	initial begin
		air_rx_valid = 1'b0;
		air_rx_pkt = '1;
		air_tx_ready = 1'b1;
		took = 1'b0;
	end

	task automatic send(input air_packet_t p);
		send_q.push_back(p);
	endtask : send

	// ==========================================================
	// Handshake sampling
	always @(posedge mclk) begin
		took <= air_rx_valid && air_rx_ready;
		if (air_tx_valid && air_tx_ready) begin
			heard_q.push_back(air_tx_pkt);
		end
	end

	// ==========================================================
	// Offer and release packets, slow or prompt listener
	always @(negedge mclk) begin
		air_tx_ready <= !stall;
		if (took) begin
			air_rx_valid <= 1'b0;
			air_rx_pkt <= ~air_rx_pkt;
		end else if (!air_rx_valid && send_q.size() > 0) begin
			air_rx_valid <= 1'b1;
			air_rx_pkt <= send_q.pop_front();
		end
	end
endmodule : radio_air_model

/* File: testbench.sv */
// Self-checking bench for the repeater forwarding block.
// Assumes the air-side partner model; inputs change on the falling edge.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import repeater_pkg::*;

	localparam int LIMIT = 20000;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] mode_select_pins;
	logic factory_default_req, cfg_wr_valid, cfg_wr_ack, cfg_wr_err, stall;
	cfg_write_t cfg_wr;
	logic air_rx_valid, air_rx_ready, air_tx_valid, air_tx_ready;
	air_packet_t air_rx_pkt, air_tx_pkt;
	logic user_tx_valid, user_tx_ready, user_rx_valid, status_aux, low_power, repeating;
	logic [7:0] user_tx_data, user_rx_data;
	logic [7:0] user_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #50 mclk = ~mclk;

	radio_repeater_forwarding DUT (.mclk(mclk), .rst_b(rst_b), .mode_select_pins(mode_select_pins),
		.factory_default_req(factory_default_req), .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
		.cfg_wr_ack(cfg_wr_ack), .cfg_wr_err(cfg_wr_err), .air_rx_valid(air_rx_valid),
		.air_rx_ready(air_rx_ready), .air_rx_pkt(air_rx_pkt), .air_tx_valid(air_tx_valid),
		.air_tx_ready(air_tx_ready), .air_tx_pkt(air_tx_pkt), .user_tx_valid(user_tx_valid),
		.user_tx_ready(user_tx_ready), .user_tx_data(user_tx_data), .user_rx_valid(user_rx_valid),
		.user_rx_data(user_rx_data), .status_aux(status_aux), .low_power(low_power), .repeating(repeating));

	radio_air_model partner (.mclk(mclk), .stall(stall), .air_rx_valid(air_rx_valid),
		.air_rx_ready(air_rx_ready), .air_rx_pkt(air_rx_pkt), .air_tx_valid(air_tx_valid),
		.air_tx_ready(air_tx_ready), .air_tx_pkt(air_tx_pkt));

	// ==========================================================
	// Reporting
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	always @(posedge mclk) begin
		cycles++;
		if (user_rx_valid === 1'b1) begin
			user_q.push_back(user_rx_data);
		end
		if (cycles == LIMIT) begin
			$display("Timeout after %0d cycles", cycles);
			fail_count++;
			end_sim();
		end
	end

	// ==========================================================
	// Drivers
	task automatic ticks(input int n);
		repeat (n) @(negedge mclk);
	endtask : ticks

	task automatic set_mode(input op_mode_t m);
		@(negedge mclk);
		mode_select_pins = m;
		ticks(4);
	endtask : set_mode

	task automatic cfg_write(input logic [3:0] idx, input logic [7:0] val, input logic ok);
		@(negedge mclk);
		cfg_wr_valid = 1'b1;
		cfg_wr = '{index: idx, value: val};
		@(negedge mclk);
		cfg_wr_valid = 1'b0;
		check("cfg_wr_ack", cfg_wr_ack, ok);
		check("cfg_wr_err", cfg_wr_err, !ok);
	endtask : cfg_write

	task automatic air_xfer(input logic [31:0] p);
		partner.send(p);
		ticks(24);
	endtask : air_xfer

	task automatic heard(input int i, input logic [31:0] exp);
		check("air_tx_pkt", partner.heard_q[i], exp);
	endtask : heard

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		ticks(5);
		check("status_aux in reset", status_aux, 1'b0);
		rst_b = 1'b1;
		ticks(8);
		check("status_aux reloading", status_aux, 1'b0);
		ticks(1);
		check("status_aux running", status_aux, 1'b1);
	endtask : t_reset

	task automatic t_default;
		air_xfer(32'h00_0000_A5);
		air_xfer(32'h00_0001_5A);
		air_xfer(32'h01_0000_66);
		check("user rx count", user_q.size(), 1);
		check("user rx data", user_q[0], 8'hA5);
		check("user_tx_ready", user_tx_ready, 1'b1);
		@(negedge mclk);
		user_tx_valid = 1'b1;
		user_tx_data = 8'h3C;
		@(negedge mclk);
		user_tx_valid = 1'b0;
		ticks(8);
		heard(0, 32'h00_0000_3C);
		partner.heard_q.delete();
	endtask : t_default

	task automatic t_config;
		cfg_write(IDX_CHANNEL, 8'h10, 1'b0);
		set_mode(MODE_CONFIG);
		cfg_write(IDX_CHANNEL, 8'h50, 1'b1);
		cfg_write(IDX_CHANNEL, 8'h51, 1'b0);
		cfg_write(4'h9, 8'h00, 1'b0);
		cfg_write(IDX_KEY_HIGH, 8'hFF, 1'b1);
		cfg_write(IDX_KEY_LOW, 8'hFF, 1'b1);
		cfg_write(IDX_ADDR_HIGH, 8'h08, 1'b1);
		cfg_write(IDX_ADDR_LOW, 8'h33, 1'b1);
		cfg_write(IDX_NETWORK_IDENTIFIER, 8'hFF, 1'b1);
		cfg_write(IDX_NETWORK_IDENTIFIER, 8'h77, 1'b1);
		cfg_write(IDX_REG3, 8'h20, 1'b1);
		ticks(2);
		check("repeating in config", repeating, 1'b0);
	endtask : t_config

	task automatic t_repeat;
		set_mode(MODE_NORMAL);
		check("repeating", repeating, 1'b1);
		check("user_tx_ready", user_tx_ready, 1'b0);
		set_mode(MODE_WOR);
		check("low_power", low_power, 1'b0);
		set_mode(MODE_NORMAL);
		air_xfer(32'h08_1234_11);
		air_xfer(32'h33_1234_22);
		air_xfer(32'h08_1234_22);
		air_xfer(32'h77_1234_44);
		air_xfer(32'h55_1234_45);
		air_xfer(32'h08_0833_55);
		check("forward count", partner.heard_q.size(), 3);
		heard(0, 32'h33_1234_11);
		heard(1, 32'h08_1234_22);
		heard(2, 32'h33_0833_55);
		check("user rx while repeating", user_q.size(), 1);
		partner.heard_q.delete();
	endtask : t_repeat

	task automatic t_fill;
		stall = 1'b1;
		for (int i = 0; i < 12; i++) begin
			partner.send({8'h33, 16'h0100 + 16'(i), 8'(i)});
		end
		ticks(60);
		check("air_rx_ready full", air_rx_ready, 1'b0);
		check("left unsent", partner.send_q.size(), 1);
		check("air_tx_valid stalled", air_tx_valid, 1'b1);
		check("air_tx_pkt stands", air_tx_pkt, 32'h08_0100_00);
		stall = 1'b0;
		ticks(80);
		check("drained count", partner.heard_q.size(), 12);
		for (int i = 0; i < 12; i++) begin
			heard(i, {8'h08, 16'h0100 + 16'(i), 8'(i)});
		end
	endtask : t_fill

	task automatic t_sleep_factory;
		int n;
		set_mode(MODE_CONFIG);
		@(negedge mclk);
		factory_default_req = 1'b1;
		@(negedge mclk);
		factory_default_req = 1'b0;
		set_mode(MODE_SLEEP);
		check("low_power repeating", low_power, 1'b0);
		@(negedge mclk);
		mode_select_pins = MODE_NORMAL;
		n = 0;
		while (status_aux !== 1'b0 && n < 8) begin
			ticks(1);
			n++;
		end
		check("status_aux on wake", status_aux, 1'b0);
		n = 0;
		while (status_aux !== 1'b1 && n < 20) begin
			ticks(1);
			n++;
		end
		check("status_aux after reload", status_aux, 1'b1);
		check("reload cycles", n, PARAM_COUNT);
		ticks(3);
		check("repeating after factory", repeating, 1'b0);
		air_xfer(32'h00_0000_C3);
		check("user rx data", user_q[user_q.size() - 1], 8'hC3);
		set_mode(MODE_WOR);
		check("low_power repeater off", low_power, 1'b1);
	endtask : t_sleep_factory

	// ==========================================================
	// Main sequence
	initial begin
		mode_select_pins = MODE_NORMAL;
		factory_default_req = 1'b0;
		cfg_wr_valid = 1'b0;
		cfg_wr = '0;
		user_tx_valid = 1'b0;
		user_tx_data = 8'h00;
		stall = 1'b0;
		t_reset();
		t_default();
		t_config();
		t_repeat();
		t_fill();
		t_sleep_factory();
		end_sim();
	end
endmodule : testbench
